/* File: src/sdic_pkg.sv */
// Package: constants and types for the serial converter input control
package sdic_pkg;

    // ------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int MODE_HI_POS = 13;
    localparam int MODE_LO_POS = 12;
    localparam int CODE_MSB = 11;
    localparam int CODE_LSB = 0;
    localparam int BITCNT_W = 5;
    localparam logic [BITCNT_W-1:0] LAST_BIT = 5'h0f;
    localparam logic [CODE_BITS-1:0] CODE_RESET = 12'h000;
    localparam logic [WORD_BITS-1:0] SHIFT_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 40000;
    localparam int WAKE_TIME_NS = 2500;
    localparam int WAKE_CYCLES = (WAKE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WAKE_W = 8;

    // ------------------------------------------------------------
    // Power modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SDIC_PM_NORMAL = 2'h0,
        SDIC_PM_1K = 2'h1,
        SDIC_PM_100K = 2'h2,
        SDIC_PM_HIZ = 2'h3
    } sdic_pmode_t;

    // Converter state shown to the analog side
    typedef struct packed {
        sdic_pmode_t mode;
        logic [CODE_BITS-1:0] code;
    } sdic_conv_t;

    // Synchronised link pins
    typedef struct packed {
        logic frame_n;
        logic sclk;
        logic sdata;
    } sdic_link_t;

endpackage

/* File: src/sdic_sync.sv */
// Two-flop synchroniser for the link pins
`timescale 1ns/1ps
module sdic_sync
    import sdic_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pins in, synchronised out
    input wire sdic_link_t pins,
    output sdic_link_t synced
);
    sdic_link_t meta_r;
    sdic_link_t meta_nxt;
    sdic_link_t sync_r;
    sdic_link_t sync_nxt;

    always_comb
    begin
        meta_nxt = pins;
        sync_nxt = meta_r;
        // First stage takes the raw pins only, reset acts on the second
        if (!rst_n)
        begin
            sync_nxt = '{frame_n: 1'b1, sclk: 1'b1, sdata: 1'b0};
        end
    end

    always_ff @(posedge sys_clk)
    begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
    end

    assign synced = sync_r;
endmodule // sdic_sync

/* File: src/sdic_core.sv */
// Serial input control of a 12-bit voltage-output converter
`timescale 1ns/1ps
module sdic_core
    import sdic_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Serial link pins
    input wire logic frame_n,
    input wire logic shift_clk,
    input wire logic sdata,
    // Converter controls
    output logic [CODE_BITS-1:0] conv_code,
    output sdic_pmode_t power_mode,
    output logic amp_enable,
    output logic term_1k,
    output logic term_100k,
    output logic out_valid,
    output logic word_done
);
    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    sdic_link_t link;
    sdic_link_t prev_r;
    sdic_link_t prev_nxt;

    sdic_link_t pin_bus;
    assign pin_bus = '{frame_n: frame_n, sclk: shift_clk, sdata: sdata};

    sdic_sync u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pins(pin_bus),
        .synced(link)
    );

    logic sclk_fall;
    logic frame_fall;
    logic frame_rise;
    assign sclk_fall = prev_r.sclk && !link.sclk;
    assign frame_fall = prev_r.frame_n && !link.frame_n;
    assign frame_rise = !prev_r.frame_n && link.frame_n;

    // ------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SHIFT = 3'h2,
        ST_DONE = 3'h4
    } sdic_state_t;

    sdic_state_t state_r;
    sdic_state_t state_nxt;
    logic [WORD_BITS-1:0] shift_r;
    logic [WORD_BITS-1:0] shift_nxt;
    logic [BITCNT_W-1:0] cnt_r;
    logic [BITCNT_W-1:0] cnt_nxt;
    sdic_conv_t conv_r;
    sdic_conv_t conv_nxt;
    logic done_r;
    logic done_nxt;
    logic [WAKE_W-1:0] wake_r;
    logic [WAKE_W-1:0] wake_nxt;
    logic valid_r;
    logic valid_nxt;
    logic [WORD_BITS-1:0] word;

    if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << WAKE_W))
    begin : g_wake_check
        $error("Wake count does not fit its counter");
    end

    always_comb
    begin
        prev_nxt = link;
        state_nxt = state_r;
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        conv_nxt = conv_r;
        done_nxt = 1'b0;
        wake_nxt = wake_r;
        word = {shift_r[WORD_BITS-2:0], link.sdata};
        unique case (state_r)
            ST_IDLE:
            begin
                if (frame_fall)
                begin
                    state_nxt = ST_SHIFT;
                    shift_nxt = SHIFT_RESET;
                    cnt_nxt = '0;
                end
            end
            ST_SHIFT:
            begin
                if (frame_rise)
                begin
                    state_nxt = ST_IDLE;
                    shift_nxt = SHIFT_RESET;
                    cnt_nxt = '0;
                end
                else if (sclk_fall)
                begin
                    shift_nxt = word;
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == LAST_BIT)
                    begin
                        state_nxt = ST_DONE;
                        // Top two bits dropped
                        conv_nxt.mode = sdic_pmode_t'({word[MODE_HI_POS],
                            word[MODE_LO_POS]});
                        conv_nxt.code = word[CODE_MSB:CODE_LSB];
                        done_nxt = 1'b1;
                    end
                end
            end
            ST_DONE:
            begin
                if (frame_rise)
                    state_nxt = ST_IDLE;
            end
            default:
                state_nxt = ST_IDLE;
        endcase
        // Wake recovery countdown
        if (conv_nxt.mode != SDIC_PM_NORMAL)
            wake_nxt = WAKE_W'(WAKE_CYCLES);
        else if (wake_r != '0)
            wake_nxt = wake_r - 8'h01;
        // Old count used so the full recovery time elapses
        valid_nxt = (conv_nxt.mode == SDIC_PM_NORMAL) && (wake_r == '0);
        if (!rst_n)
        begin
            prev_nxt = '{frame_n: 1'b1, sclk: 1'b1, sdata: 1'b0};
            state_nxt = ST_IDLE;
            shift_nxt = SHIFT_RESET;
            cnt_nxt = '0;
            conv_nxt = '{mode: SDIC_PM_NORMAL, code: CODE_RESET};
            done_nxt = 1'b0;
            wake_nxt = '0;
            valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        prev_r <= prev_nxt;
        state_r <= state_nxt;
        shift_r <= shift_nxt;
        cnt_r <= cnt_nxt;
        conv_r <= conv_nxt;
        done_r <= done_nxt;
        wake_r <= wake_nxt;
        valid_r <= valid_nxt;
    end

    // ------------------------------------------------------------
    // Output stage controls
    // ------------------------------------------------------------
    logic amp_r;
    logic amp_nxt;
    logic t1k_r;
    logic t1k_nxt;
    logic t100k_r;
    logic t100k_nxt;

    // Reset forces normal mode, so these follow it without a reset term
    always_comb
    begin
        amp_nxt = (conv_nxt.mode == SDIC_PM_NORMAL);
        t1k_nxt = (conv_nxt.mode == SDIC_PM_1K);
        t100k_nxt = (conv_nxt.mode == SDIC_PM_100K);
    end

    always_ff @(posedge sys_clk)
    begin
        amp_r <= amp_nxt;
        t1k_r <= t1k_nxt;
        t100k_r <= t100k_nxt;
    end

    assign conv_code = conv_r.code;
    assign power_mode = conv_r.mode;
    assign amp_enable = amp_r;
    assign term_1k = t1k_r;
    assign term_100k = t100k_r;
    assign out_valid = valid_r;
    assign word_done = done_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_abort_keeps: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == ST_SHIFT && frame_rise) |=> $stable(conv_r))
        else $error("Aborted frame changed converter state");
    a_abort_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == ST_SHIFT && frame_rise) |=> (shift_r == '0 && state_r == ST_IDLE))
        else $error("Abort did not clear shifter");
    a_done_ignore: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == ST_DONE) |=> $stable(conv_r))
        else $error("Edge after execution changed state");
    a_exec_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
        word_done |-> (conv_code == $past(word[CODE_MSB:CODE_LSB])))
        else $error("Executed code mismatch");
    a_exec_sixteen: assert property (@(posedge sys_clk) disable iff (!rst_n)
        word_done |-> ($past(cnt_r) == LAST_BIT))
        else $error("Execution not on sixteenth edge");
    a_only_on_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !word_done |-> $stable(conv_r))
        else $error("Converter changed without execution");
    a_start_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == ST_IDLE && !frame_fall) |=> state_r == ST_IDLE)
        else $error("Frame started without select fall");
    a_term_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (power_mode != SDIC_PM_NORMAL) |-> !amp_enable)
        else $error("Amplifier on in power-down");
    a_wake_time: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(amp_enable) |-> !out_valid [*8])
        else $error("Output valid before recovery");
    a_wake_exact: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(amp_enable) |-> ##62 !out_valid ##1 out_valid)
        else $error("Output valid not at end of recovery");
    a_reset_zero: assert property (@(posedge sys_clk)
        $rose(rst_n) |-> (conv_code == CODE_RESET))
        else $error("Code not zero after reset");

    c_write: cover property (@(posedge sys_clk) disable iff (!rst_n) word_done);
    c_abort: cover property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == ST_SHIFT && frame_rise);
    c_pdown: cover property (@(posedge sys_clk) disable iff (!rst_n)
        power_mode == SDIC_PM_HIZ);
    c_wake: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(out_valid));
endmodule // sdic_core

/* File: dv/sdic_host_model.sv */
// Host serial master model driving the three link pins
`timescale 1ns/1ps
module sdic_host_model
(
    // Clock
    input wire logic sys_clk,
    // Link pins
    output logic frame_n,
    output logic shift_clk,
    output logic sdata
);
    // ------------------------------------------------------------
    // Idle levels and frame sender
    // ------------------------------------------------------------
    initial
    begin
        frame_n = 1'b1;
        shift_clk = 1'b1;
        sdata = 1'b0;
    end

    // Half link period is 4 clocks of 40 ns
    task automatic send(input logic [15:0] w, input int nbits, input bit rel);
        if (frame_n === 1'b0)
        begin
            frame_n = 1'b1;
            repeat (4) @(negedge sys_clk);
        end
        frame_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        for (int i = 0; i < nbits; i++)
        begin
            sdata = (i < 16) ? w[15 - i] : ~w[i - 16];
            repeat (4) @(negedge sys_clk);
            shift_clk = 1'b0;
            repeat (4) @(negedge sys_clk);
            shift_clk = 1'b1;
        end
        repeat (4) @(negedge sys_clk);
        sdata = ~sdata;
        if (rel)
            frame_n = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask
endmodule // sdic_host_model

/* File: dv/serial_dac_input_control_bench.sv */
// Self-checking bench for the serial converter input control
`timescale 1ns/1ps
module serial_dac_input_control_bench;
    import sdic_pkg::*;
    // ------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic frame_n, shift_clk, sdata, amp_enable, term_1k, term_100k, out_valid, word_done;
    logic [CODE_BITS-1:0] conv_code;
    sdic_pmode_t power_mode;
    logic [15:0] w;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    int done_count = 0;
    int exp_done = 0;
    int exp_code = 0;
    int exp_mode = 0;

    always #20 sys_clk = ~sys_clk;

    sdic_host_model host (.sys_clk(sys_clk), .frame_n(frame_n), .shift_clk(shift_clk),
        .sdata(sdata));

    sdic_core uut (.sys_clk(sys_clk), .rst_n(rst_n), .frame_n(frame_n), .shift_clk(shift_clk),
        .sdata(sdata), .conv_code(conv_code), .power_mode(power_mode), .amp_enable(amp_enable),
        .term_1k(term_1k), .term_100k(term_100k), .out_valid(out_valid), .word_done(word_done));

    // ------------------------------------------------------------
    // Checking tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        if (miscompares == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic compare_state();
        check("conv_code", 16'(exp_code), 16'(conv_code));
        check("power_mode", 16'(exp_mode), 16'(power_mode));
        check("amp_enable", 16'(exp_mode == 0), 16'(amp_enable));
        check("term_1k", 16'(exp_mode == 1), 16'(term_1k));
        check("term_100k", 16'(exp_mode == 2), 16'(term_100k));
        check("word_done", 16'(exp_done), 16'(done_count));
    endtask

    // Short frames leave the model untouched, full ones execute
    task automatic frame(input logic [15:0] fw, input int nbits, input bit rel);
        host.send(fw, nbits, rel);
        if (nbits >= 16)
        begin
            exp_code = fw[11:0];
            exp_mode = fw[13:12];
            exp_done++;
        end
        repeat (8) @(negedge sys_clk);
        compare_state();
    endtask

    // ------------------------------------------------------------
    // Pulse counter and timeout
    // ------------------------------------------------------------
    always @(negedge sys_clk)
    begin
        cycles++;
        if (word_done === 1'b1)
            done_count++;
        if (cycles > 20000)
        begin
            miscompares++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(97991));
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        compare_state();
        check("out_valid", 16'h0001, 16'(out_valid));
        frame(16'hcfff, 16, 1'b1);
        frame(16'h0000, 16, 1'b1);
        for (int m = 0; m < 4; m++)
        begin
            w = 16'($urandom);
            w[13:12] = m[1:0];
            frame(w, 16, 1'b1);
        end
        check("out_valid", 16'h0000, 16'(out_valid));
        frame(16'($urandom) & 16'hcfff, 16, 1'b1);
        check("out_valid", 16'h0000, 16'(out_valid));
        repeat (45) @(negedge sys_clk);
        check("out_valid", 16'h0000, 16'(out_valid));
        repeat (10) @(negedge sys_clk);
        check("out_valid", 16'h0001, 16'(out_valid));
        frame(16'($urandom), 10, 1'b1);
        frame(16'($urandom), 15, 1'b1);
        frame(16'($urandom), 16, 1'b1);
        frame(16'($urandom), 20, 1'b0);
        frame(16'($urandom), 16, 1'b1);
        for (int k = 0; k < 8; k++)
            frame(16'($urandom), 16, k[0]);
        end_sim();
    end
endmodule // serial_dac_input_control_bench
